// file: vcl_clamp_timing.sv
// Clamp window generation, register port and vertical sync pass-through
module vcl_clamp_timing
    import vcl_pkg::*;
#(
    parameter int CHANNELS = 3
) (
    // Pixel clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Register port from the serial interface
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_q,
    // Sync and clamp pins
    input wire logic hsync,
    input wire logic clamp_pin,
    input wire logic vsync,
    input wire logic vsync_alt,
    output logic vertical_sync_output_q,
    output logic coast_q,
    // Converter side
    input wire logic [7:0] adc_code [CHANNELS],
    output logic [7:0] offset [CHANNELS],
    output logic [CHANNELS-1:0] midscale_q,
    output logic clamp_q
);
    logic [7:0] target_sel_q;
    logic [7:0] start_delay_q;
    logic [7:0] length_q;
    logic [7:0] control_q;
    logic hs_q;
    logic hs_trail;
    logic [8:0] count_q;
    logic int_clamp_q;
    logic ext_active;
    logic clamp_d;
    logic vs_sel;

    typedef enum logic [1:0] {
        VCL_IDLE_type = 2'b00,
        VCL_WAIT_type = 2'b01,
        VCL_CLAMP_type = 2'b10
    } vcl_state_type;
    vcl_state_type state_q;

    // Register writes
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            target_sel_q <= VCL_TARGET_SEL_RST;
            start_delay_q <= VCL_START_DELAY_RST; // RULE9
            length_q <= VCL_LENGTH_RST; // RULE9
            control_q <= VCL_CONTROL_RST;
        end else if (reg_wr) begin
            unique case (reg_addr)
                VCL_TARGET_SEL_OFS: target_sel_q <= {5'h00, reg_wdata[2:0]}; // RULE5
                VCL_START_DELAY_OFS: start_delay_q <= reg_wdata; // RULE2
                VCL_LENGTH_OFS: length_q <= reg_wdata; // RULE2
                VCL_CONTROL_OFS: control_q <= {4'h0, reg_wdata[3:0]};
                default: ;
            endcase
        end
    end

    // Register reads, clamp state shown in control bit 7
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                VCL_TARGET_SEL_OFS: reg_rdata_q <= target_sel_q;
                VCL_START_DELAY_OFS: reg_rdata_q <= start_delay_q;
                VCL_LENGTH_OFS: reg_rdata_q <= length_q;
                VCL_CONTROL_OFS: reg_rdata_q <= {clamp_q, 3'h0, control_q[3:0]};
                default: reg_rdata_q <= 8'h00;
            endcase
        end
    end

    // Hsync trailing edge from raw pin history, so a polarity change alone makes no edge
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            hs_q <= 1'b0;
        end else begin
            hs_q <= hsync;
        end
    end
    assign hs_trail = (hs_q ^ control_q[VCL_CTL_HPOL_BIT]) && !(hsync ^ control_q[VCL_CTL_HPOL_BIT]);

    // Internal clamp window generator
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= VCL_IDLE_type;
            count_q <= 9'h000;
            int_clamp_q <= 1'b0;
        end else if (hs_trail) begin
            count_q <= 9'h000; // RULE11
            int_clamp_q <= 1'b0;
            state_q <= VCL_WAIT_type; // RULE1
        end else begin
            unique case (state_q)
                VCL_IDLE_type: int_clamp_q <= 1'b0;
                VCL_WAIT_type: begin
                    if (count_q[7:0] == start_delay_q) begin
                        count_q <= 9'h000;
                        int_clamp_q <= (length_q != 8'h00); // RULE1
                        state_q <= (length_q != 8'h00) ? VCL_CLAMP_type : VCL_IDLE_type;
                    end else begin
                        count_q <= count_q + 9'h001;
                    end
                end
                VCL_CLAMP_type: begin
                    if (count_q[7:0] == length_q - 8'h01) begin
                        int_clamp_q <= 1'b0; // RULE2
                        state_q <= VCL_IDLE_type;
                    end else begin
                        count_q <= count_q + 9'h001;
                    end
                end
                default: state_q <= VCL_IDLE_type;
            endcase
        end
    end

    // Clamp source select and pin polarity
    assign ext_active = clamp_pin ^ control_q[VCL_CTL_POL_BIT]; // RULE4
    assign clamp_d = control_q[VCL_CTL_EXT_BIT] ? ext_active : int_clamp_q; // RULE3 RULE10 RULE11

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            clamp_q <= 1'b0;
            midscale_q <= '0;
        end else begin
            clamp_q <= clamp_d;
            midscale_q <= target_sel_q[CHANNELS-1:0]; // RULE5
        end
    end

    // Vertical sync selection, pass-through and coast
    assign vs_sel = control_q[VCL_CTL_VSEL_BIT] ? vsync_alt : vsync;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            vertical_sync_output_q <= 1'b0;
            coast_q <= 1'b0;
        end else begin
            vertical_sync_output_q <= vs_sel; // RULE8
            coast_q <= vs_sel; // RULE8
        end
    end

    // One offset servo per converter
    for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
        vcl_offset_loop u_loop (
            .ref_clk(ref_clk),
            .reset_n(reset_n),
            .clamp_active(clamp_q),
            .midscale_sel(midscale_q[i]),
            .adc_code(adc_code[i]),
            .offset_q(offset[i])
        );
    end

    // Clamp opens placement+1 cycles after the trailing edge
    property p_start;
        @(posedge ref_clk) disable iff (!reset_n)
            (hs_trail && !reg_wr && !control_q[VCL_CTL_EXT_BIT] && start_delay_q == 8'h08 && length_q != 8'h00)
            ##1 (!hs_trail && !reg_wr) [*8] ##1 (!hs_trail && !reg_wr) |=> int_clamp_q;
    endproperty
    a_start: assert property (p_start) else $error("clamp did not start after placement"); // RULE1

    // Clamp not open during placement wait
    property p_wait;
        @(posedge ref_clk) disable iff (!reset_n) state_q == VCL_WAIT_type |-> !int_clamp_q;
    endproperty
    a_wait: assert property (p_wait) else $error("clamp open during wait"); // RULE1

    // Helper: cycles the window has been open, and whether no write or edge disturbed it
    logic [8:0] win_cnt_q;
    logic win_clean_q;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            win_cnt_q <= 9'h000;
            win_clean_q <= 1'b1;
        end else begin
            win_cnt_q <= int_clamp_q ? win_cnt_q + 9'h001 : 9'h000;
            win_clean_q <= int_clamp_q ? (win_clean_q && !hs_trail && !reg_wr) : 1'b1;
        end
    end

    // Undisturbed clamp window lasts exactly the programmed length
    property p_len;
        @(posedge ref_clk) disable iff (!reset_n)
            $fell(int_clamp_q) && win_clean_q |-> win_cnt_q == {1'b0, length_q};
    endproperty
    a_len: assert property (p_len) else $error("clamp window length wrong"); // RULE2

    // External select follows the pin
    property p_ext;
        @(posedge ref_clk) disable iff (!reset_n)
            control_q[VCL_CTL_EXT_BIT] && !reg_wr |=> clamp_q == $past(ext_active);
    endproperty
    a_ext: assert property (p_ext) else $error("external clamp not followed"); // RULE3

    // Polarity inverts the pin
    property p_pol;
        @(posedge ref_clk) disable iff (!reset_n)
            control_q[VCL_CTL_EXT_BIT] && control_q[VCL_CTL_POL_BIT] && !reg_wr |=> clamp_q == !$past(clamp_pin);
    endproperty
    a_pol: assert property (p_pol) else $error("clamp polarity wrong"); // RULE4

    // Target bits reach the channels
    property p_tgt;
        @(posedge ref_clk) disable iff (!reset_n) ##1 midscale_q == $past(target_sel_q[CHANNELS-1:0]);
    endproperty
    a_tgt: assert property (p_tgt) else $error("target select not applied"); // RULE5

    // Vertical sync passes through and feeds coast
    property p_vs;
        @(posedge ref_clk) disable iff (!reset_n)
            ##1 vertical_sync_output_q == $past(vs_sel) && coast_q == vertical_sync_output_q;
    endproperty
    a_vs: assert property (p_vs) else $error("vertical sync not forwarded"); // RULE8

    // Trailing edge restarts the count
    property p_restart;
        @(posedge ref_clk) disable iff (!reset_n) hs_trail |=> state_q == VCL_WAIT_type && count_q == 9'h000;
    endproperty
    a_restart: assert property (p_restart) else $error("placement not restarted"); // RULE11
endmodule

// file: vcl_offset_loop.sv
// Per-channel offset servo that steers converter output to a clamp target
module vcl_offset_loop
    import vcl_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Control
    input wire logic clamp_active,
    input wire logic midscale_sel,
    input wire logic [7:0] adc_code,
    // Result
    output logic [7:0] offset_q
);
    logic [7:0] target;

    // Target choice per channel
    assign target = midscale_sel ? VCL_CODE_MID : VCL_CODE_GND; // RULE6 RULE7

    // Step offset during clamp, hold it otherwise
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            offset_q <= VCL_OFFSET_RST;
        end else if (clamp_active) begin
            if (adc_code > target && offset_q != 8'h00) begin
                offset_q <= offset_q - 8'h01; // RULE7
            end else if (adc_code < target && offset_q != 8'hff) begin
                offset_q <= offset_q + 8'h01; // RULE6
            end
        end
    end

    // Offset frozen outside the clamp window
    property p_hold;
        @(posedge ref_clk) disable iff (!reset_n) !clamp_active |=> $stable(offset_q);
    endproperty
    a_hold: assert property (p_hold) else $error("offset moved outside clamp"); // RULE7
endmodule

// file: vcl_pkg.sv
// Package with register offsets, reset values and clamp target codes
// Notes on behaviour
// RULE1: Internal generator waits placement count after hsync trailing edge, then clamps.
// RULE2: Placement and duration are 8-bit; duration gives clamp length in pixel clocks.
// RULE3: External select 1 takes clamp from pin; source drives it in black period.
// RULE4: Clamp pin active level follows the clamp polarity control bit.
// RULE5: Three per-channel target bits sit in bits 0 to 2 of one register.
// RULE6: Midscale channels are clamped so converter output reads code 80h.
// RULE7: Ground channels clamp black to 00h and hold offset outside the window.
// RULE8: Selected vertical sync input drives coast generation and the sync output.
// RULE9: Host should start with placement 08h and duration 14h.
// RULE10: Works without hsync when external clock and external clamp are used.
// RULE11: Placement count restarts on each hsync trailing edge; own timing ignored when pin chosen.
package vcl_pkg;
    localparam logic [7:0] VCL_TARGET_SEL_OFS = 8'h0f;
    localparam logic [7:0] VCL_START_DELAY_OFS = 8'h10;
    localparam logic [7:0] VCL_LENGTH_OFS = 8'h11;
    localparam logic [7:0] VCL_CONTROL_OFS = 8'h12;
    localparam logic [7:0] VCL_TARGET_SEL_RST = 8'h00;
    localparam logic [7:0] VCL_START_DELAY_RST = 8'h08;
    localparam logic [7:0] VCL_LENGTH_RST = 8'h14;
    localparam logic [7:0] VCL_CONTROL_RST = 8'h00;
    localparam logic [7:0] VCL_OFFSET_RST = 8'h80;
    localparam int VCL_CTL_EXT_BIT = 0;
    localparam int VCL_CTL_POL_BIT = 1;
    localparam int VCL_CTL_VSEL_BIT = 2;
    localparam int VCL_CTL_HPOL_BIT = 3;
    localparam logic [7:0] VCL_CODE_MID = 8'h80;
    localparam logic [7:0] VCL_CODE_GND = 8'h00;
endpackage

// file: vcl_source.sv
// Graphics source model: sync pulses, clamp pin and converter codes
module vcl_source
    import vcl_pkg::*;
(
    // Clock and bench commands
    input wire logic ref_clk,
    input wire logic line_go,
    input wire logic pin_level,
    // Pins toward the block
    output logic hsync,
    output logic clamp_pin,
    // Converter model
    input wire logic [7:0] offset [3],
    output logic [7:0] adc_code [3]
);
    timeunit 1ns;
    timeprecision 1ps;
    int hs_cnt = 0;
    // Four-clock sync pulse per line, trailing edge then back porch
    always @(posedge ref_clk) begin
        if (line_go) hs_cnt <= #1 4;
        else if (hs_cnt > 0) hs_cnt <= #1 hs_cnt - 1;
    end
    assign hsync = (hs_cnt > 0);
    // Pin driven only when the bench places it in the black period
    assign clamp_pin = pin_level;
    // Black input reads back as the applied offset
    always_comb adc_code = offset;
endmodule

// file: video_clamp_timing_control_bench.sv
// Bench for clamp window, register port and sync pass-through
module video_clamp_timing_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import vcl_pkg::*;
    logic ref_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, vsync = 0, vsync_alt = 0;
    logic line_go = 0, pin_level = 0, hsync, clamp_pin, vertical_sync_output_q, coast_q, clamp_q;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_q;
    logic [7:0] adc_code [3];
    logic [7:0] offset [3];
    logic [2:0] midscale_q;
    int failures = 0, n_tests = 0, cyc = 0, r3, w, r;
    vcl_clamp_timing #(.CHANNELS(3)) dut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
        .hsync(hsync), .clamp_pin(clamp_pin), .vsync(vsync), .vsync_alt(vsync_alt),
        .vertical_sync_output_q(vertical_sync_output_q), .coast_q(coast_q), .adc_code(adc_code),
        .offset(offset), .midscale_q(midscale_q), .clamp_q(clamp_q));
    vcl_source src (.ref_clk(ref_clk), .line_go(line_go), .pin_level(pin_level), .hsync(hsync),
        .clamp_pin(clamp_pin), .offset(offset), .adc_code(adc_code));
    // Clock and run ceiling
    initial forever #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            close_out();
        end
    end
    task automatic close_out();
        $display("failures=%0d n_tests=%0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk) #1 reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge ref_clk) #1 reg_wr = 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk) #1 reg_rd = 1;
        reg_addr = a;
        @(posedge ref_clk) #1 reg_rd = 0;
        chk(reg_rdata_q, exp);
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // One line: cycles from sync start to clamp, then clamp width
    task automatic line(output int rise, output int width);
        @(posedge ref_clk) #1 line_go = 1;
        @(posedge ref_clk) #1 line_go = 0;
        rise = 0;
        width = 0;
        while (clamp_q !== 1'b1 && rise < 600) begin
            ticks(1);
            rise++;
        end
        while (clamp_q === 1'b1 && width < 600) begin
            ticks(1);
            width++;
        end
    endtask
    task automatic t_regs();
        rd(VCL_TARGET_SEL_OFS, 8'h00);
        rd(VCL_START_DELAY_OFS, 8'h08);
        rd(VCL_LENGTH_OFS, 8'h14);
        rd(VCL_CONTROL_OFS, 8'h00);
        rd(8'h20, 8'h00);
        wr(8'h20, 8'h5a);
        rd(8'h20, 8'h00);
        wr(VCL_TARGET_SEL_OFS, 8'hff);
        rd(VCL_TARGET_SEL_OFS, 8'h07);
        chk(midscale_q, 3'b111);
    endtask
    task automatic t_internal();
        wr(VCL_LENGTH_OFS, 8'h05);
        wr(VCL_START_DELAY_OFS, 8'h03);
        line(r3, w);
        chk(w, 5);
        wr(VCL_START_DELAY_OFS, 8'h08);
        line(r, w);
        chk(r - r3, 5);
        wr(VCL_LENGTH_OFS, 8'h14);
        line(r, w);
        chk(w, 20);
        // Inverted hsync: trailing edge comes at the pulse start, four clocks sooner
        wr(VCL_CONTROL_OFS, 8'h08);
        line(r, w);
        chk(r - r3, 1);
        wr(VCL_CONTROL_OFS, 8'h00);
        wr(VCL_START_DELAY_OFS, 8'hff);
        wr(VCL_LENGTH_OFS, 8'hff);
        line(r, w);
        chk(r - r3, 252);
        chk(w, 255);
        wr(VCL_START_DELAY_OFS, 8'h20);
        wr(VCL_LENGTH_OFS, 8'h00);
        line(r, w);
        chk(w, 0);
        wr(VCL_LENGTH_OFS, 8'h05);
        @(posedge ref_clk) #1 line_go = 1;
        @(posedge ref_clk) #1 line_go = 0;
        ticks(12);
        line(r, w);
        chk(r - r3, 29);
    endtask
    task automatic t_external();
        wr(VCL_START_DELAY_OFS, 8'h02);
        wr(VCL_CONTROL_OFS, 8'h01);
        line(r, w);
        chk(clamp_q, 1'b0);
        pin_level = 1;
        ticks(2);
        chk(clamp_q, 1'b1);
        ticks(7);
        chk(clamp_q, 1'b1);
        pin_level = 0;
        ticks(2);
        chk(clamp_q, 1'b0);
        wr(VCL_CONTROL_OFS, 8'h03);
        ticks(2);
        chk(clamp_q, 1'b1);
        pin_level = 1;
        ticks(2);
        chk(clamp_q, 1'b0);
    endtask
    task automatic t_vsync();
        wr(VCL_CONTROL_OFS, 8'h00);
        vsync = 1;
        ticks(2);
        chk({vertical_sync_output_q, coast_q}, 2'b11);
        wr(VCL_CONTROL_OFS, 8'h04);
        ticks(2);
        chk({vertical_sync_output_q, coast_q}, 2'b00);
        vsync_alt = 1;
        vsync = 0;
        ticks(2);
        chk({vertical_sync_output_q, coast_q}, 2'b11);
    endtask
    task automatic t_targets();
        wr(VCL_CONTROL_OFS, 8'h00);
        wr(VCL_TARGET_SEL_OFS, 8'h05);
        ticks(1);
        chk(midscale_q, 3'b101);
        wr(VCL_START_DELAY_OFS, 8'h02);
        wr(VCL_LENGTH_OFS, 8'h08);
        repeat (3) line(r, w);
        chk(offset[0], VCL_CODE_MID);
        // Ground channel steps down one per clamp cycle: 80h less 3 lines of 8
        chk(offset[1], 8'h68);
        chk(offset[2], VCL_CODE_MID);
        r = offset[1];
        ticks(20);
        chk(offset[1], r);
        // Same channel switched to midscale climbs back to 80h
        wr(VCL_TARGET_SEL_OFS, 8'h07);
        repeat (3) line(r, w);
        chk(offset[1], VCL_CODE_MID);
    endtask
    // Reset, then every scenario in turn
    initial begin
        repeat (16) @(posedge ref_clk);
        #1 reset_n = 1;
        t_regs();
        t_internal();
        t_external();
        t_vsync();
        t_targets();
        close_out();
    end
endmodule
